// file: src/rtcx_core.sv
// Real-time clock event status, month alarm and block control over AXI4-Lite
//
// Register access over AXI4-Lite was left to the implementer.
module rtcx_core #(
  parameter int STABLE_CYCLES = rtcx_pkg::STABLE_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // AXI4-Lite write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Time-keeping side
  input wire rtcx_pkg::rtcx_evt_t evt,
  input wire logic [7:0] cur_month,
  // Outputs to the rest of the clock and the chip
  output logic irq,
  output logic wake_alarm,
  output logic block_run,
  output logic rtc_domain_rst,
  output logic time_stable
);

  // ==========================================================================
  // Reset release
  // ==========================================================================
  logic [1:0] rst_pipe;
  logic rst_n;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end

  assign rst_n = rst_pipe[1];

  // ==========================================================================
  // Helpers
  // ==========================================================================
  function automatic logic summary(input logic [2:0] flags,
                                   input logic [2:0] ie);
    summary = |(flags & ie);
  endfunction

  function automatic logic month_ok(input logic [5:0] field,
                                    input logic [7:0] month);
    month_ok = (field == 6'h00) || ({2'h0, field} == month);
  endfunction

  // ==========================================================================
  // State
  // ==========================================================================
  localparam logic [25:0] STABLE_LOAD = 26'(STABLE_CYCLES);

  rtcx_pkg::rtcx_core_t q;
  rtcx_pkg::rtcx_core_t next_q;
  logic dom_rst;
  logic srst_done;
  logic aw_fire;
  logic w_fire;
  logic ar_fire;
  logic rd_status;
  logic run;
  logic ev_per;
  logic ev_upd;
  logic ev_alm;
  logic [2:0] ev_set;

  rtcx_srst_seq u_srst (
    .clk(clk),
    .rst_n(rst_n),
    .req(q.ctl[rtcx_pkg::CTL_SOFT_RST]),
    .dom_rst(dom_rst),
    .done(srst_done)
  );

  assign s_axi_awready = !q.aw_held && !q.bvalid;
  assign s_axi_wready = !q.w_held && !q.bvalid;
  assign s_axi_arready = !q.rvalid;
  assign aw_fire = s_axi_awvalid && s_axi_awready;
  assign w_fire = s_axi_wvalid && s_axi_wready;
  assign ar_fire = s_axi_arvalid && s_axi_arready;
  assign rd_status = ar_fire && (s_axi_araddr == rtcx_pkg::ADDR_STATUS);

  // Events are only seen while the block runs and is not being reset
  assign run = q.ctl[rtcx_pkg::CTL_RUN] && !dom_rst;
  assign ev_per = run && evt.periodic;
  assign ev_upd = run && evt.update_done;
  assign ev_alm = run && q.ctl[rtcx_pkg::CTL_ALARM_EN] &&
                  evt.alarm_match &&
                  month_ok(q.month, cur_month);
  assign ev_set = {ev_per, ev_alm, ev_upd};

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb begin
    next_q = q;

    // Write channel capture; both halves may arrive in either order
    if (aw_fire) begin
      next_q.aw_held = 1'b1;
      next_q.aw_addr = s_axi_awaddr;
    end
    if (w_fire) begin
      next_q.w_held = 1'b1;
      next_q.w_data = s_axi_wdata[7:0];
      next_q.w_lane0 = s_axi_wstrb[0];
    end
    if (q.bvalid && s_axi_bready) begin
      next_q.bvalid = 1'b0;
    end
    if (q.rvalid && s_axi_rready) begin
      next_q.rvalid = 1'b0;
    end

    // Read answer; status data is taken before the clear below
    if (ar_fire) begin
      next_q.rvalid = 1'b1;
      next_q.rresp = rtcx_pkg::RESP_OKAY;
      if (s_axi_araddr == rtcx_pkg::ADDR_STATUS) begin
        next_q.rdata = {q.irq, q.flags, 4'h0};
      end else if (s_axi_araddr == rtcx_pkg::ADDR_MONTH) begin
        next_q.rdata = {2'h0, q.month};
      end else if (s_axi_araddr == rtcx_pkg::ADDR_CTL) begin
        next_q.rdata = {4'h0, q.ctl};
      end else if (s_axi_araddr == rtcx_pkg::ADDR_MODE) begin
        next_q.rdata = {1'b0, q.ie, 4'h0};
      end else begin
        next_q.rdata = 8'h00;
        next_q.rresp = rtcx_pkg::RESP_SLVERR;
      end
    end

    // Status clear by read, or by writing ones
    if (rd_status) begin
      next_q.flags = 3'h0;
    end

    // Register write once both halves are held
    if (q.aw_held && q.w_held) begin
      next_q.aw_held = 1'b0;
      next_q.w_held = 1'b0;
      next_q.bvalid = 1'b1;
      next_q.bresp = rtcx_pkg::RESP_OKAY;
      if (q.aw_addr == rtcx_pkg::ADDR_STATUS) begin
        if (q.w_lane0) begin
          next_q.flags = next_q.flags & ~q.w_data[6:4];
        end
      end else if (q.aw_addr == rtcx_pkg::ADDR_MONTH) begin
        if (q.w_lane0) begin
          next_q.month = q.w_data[5:0];
        end
      end else if (q.aw_addr == rtcx_pkg::ADDR_CTL) begin
        if (q.w_lane0) begin
          next_q.ctl[rtcx_pkg::CTL_ALARM_EN] = q.w_data[3];
          next_q.ctl[rtcx_pkg::CTL_WAKE_ROUTE] = q.w_data[2];
          next_q.ctl[rtcx_pkg::CTL_RUN] = q.w_data[0];
          // Writing zero cannot cut a reset short
          if (q.w_data[1]) begin
            next_q.ctl[rtcx_pkg::CTL_SOFT_RST] = 1'b1;
          end
        end
      end else if (q.aw_addr == rtcx_pkg::ADDR_MODE) begin
        if (q.w_lane0) begin
          next_q.ie = q.w_data[6:4];
        end
      end else begin
        next_q.bresp = rtcx_pkg::RESP_SLVERR;
      end
    end

    // A soft-reset write landing with the end of a reset starts another
    if (srst_done && !(q.aw_held && q.w_held &&
        q.aw_addr == rtcx_pkg::ADDR_CTL && q.w_lane0 && q.w_data[1])) begin
      next_q.ctl[rtcx_pkg::CTL_SOFT_RST] = 1'b0;
    end

    // Sticky flags: a new event beats a clear in the same cycle
    next_q.flags = next_q.flags | ev_set;

    // Update-ended opens a window in which the time must not move
    if (ev_upd) begin
      next_q.stable_cnt = STABLE_LOAD;
    end else if (q.stable_cnt != 26'h0) begin
      next_q.stable_cnt = q.stable_cnt - 26'h1;
    end

    next_q.wake = ev_alm && q.ctl[rtcx_pkg::CTL_WAKE_ROUTE];

    // Domain reset: flags, month, enables, hold window and wake back to defaults; control bits and bus state kept
    if (dom_rst) begin
      next_q.flags = rtcx_pkg::FLAGS_RST;
      next_q.month = rtcx_pkg::MONTH_RST;
      next_q.ie = rtcx_pkg::IE_RST;
      next_q.stable_cnt = 26'h0;
      next_q.wake = 1'b0;
    end

    next_q.irq = summary(next_q.flags, next_q.ie);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rresp = q.rresp;
  assign s_axi_rdata = {24'h0, q.rdata};
  assign irq = q.irq;
  assign wake_alarm = q.wake;
  assign block_run = q.ctl[rtcx_pkg::CTL_RUN];
  assign rtc_domain_rst = dom_rst;
  assign time_stable = (q.stable_cnt != 26'h0);

  // ==========================================================================
  // Checks
  // ==========================================================================
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  summary_flag_a: assert property (
    q.irq == |(q.flags & q.ie))
    else $error("summary flag disagrees with enabled flags");

  read_clear_a: assert property (
    rd_status && !evt.periodic && !evt.update_done && !evt.alarm_match
    |=> q.flags == 3'h0 && !q.irq)
    else $error("status read did not clear the flags");

  read_value_a: assert property (
    rd_status |=> q.rvalid && q.rdata[7:4] == {$past(q.irq), $past(q.flags)})
    else $error("status read returned wrong flags");

  periodic_set_a: assert property (
    ev_per |=> q.flags[2])
    else $error("periodic event did not set the periodic flag");

  // Only a status read, a write of one or a domain reset may drop it
  periodic_hold_a: assert property (
    q.flags[2] && !rd_status && !dom_rst &&
    !(q.aw_held && q.w_held && q.aw_addr == rtcx_pkg::ADDR_STATUS)
    |=> q.flags[2])
    else $error("periodic flag lost before the status read");

  alarm_set_a: assert property (
    ev_alm |=> q.flags[1])
    else $error("alarm event did not set the alarm flag");

  update_set_a: assert property (
    evt.update_done && run |=> q.flags[0] && time_stable)
    else $error("update end did not set flag and hold window");

  hold_count_a: assert property (
    ev_upd |=> q.stable_cnt == STABLE_LOAD)
    else $error("hold window not loaded with full count");

  month_block_a: assert property (
    q.month != 6'h00 && {2'h0, q.month} != cur_month |-> !ev_alm)
    else $error("alarm passed with a mismatching month");

  month_free_a: assert property (
    q.month == 6'h00 && evt.alarm_match && run &&
    q.ctl[rtcx_pkg::CTL_ALARM_EN] |=> q.flags[1])
    else $error("zero month field blocked the alarm");

  alarm_gate_a: assert property (
    !q.ctl[rtcx_pkg::CTL_ALARM_EN] && !q.flags[1] && !dom_rst
    |=> !q.flags[1] && !q.wake)
    else $error("alarm acted while disabled");

  wake_route_a: assert property (
    ev_alm |=> q.wake == $past(q.ctl[rtcx_pkg::CTL_WAKE_ROUTE]))
    else $error("wake output does not follow routed alarm");

  wake_cause_a: assert property (
    q.wake |-> $past(ev_alm))
    else $error("wake pulse without an alarm event");

  soft_reset_a: assert property (
    $rose(q.ctl[rtcx_pkg::CTL_SOFT_RST]) |=> dom_rst [*4]
    ##1 q.flags == 3'h0 && q.ie == 3'h0 && q.month == 6'h00)
    else $error("soft reset did not clear the block");

  ctl_kept_a: assert property (
    dom_rst && !(q.aw_held && q.w_held) |=> $stable(q.ctl[3:2]))
    else $error("domain reset disturbed the control bits");

  // A fresh soft-reset write landing in the done cycle re-arms the bit
  srst_clear_a: assert property (
    $rose(q.ctl[rtcx_pkg::CTL_SOFT_RST]) ##5 !(q.aw_held && q.w_held)
    |-> srst_done ##1 !q.ctl[rtcx_pkg::CTL_SOFT_RST])
    else $error("soft reset bit did not clear itself");

  idle_quiet_a: assert property (
    !q.ctl[rtcx_pkg::CTL_RUN] && q.flags == 3'h0 |=> q.flags == 3'h0)
    else $error("event recorded while block disabled");

  irq_level_a: assert property (
    rd_status && !evt.periodic && !evt.update_done && !evt.alarm_match
    |=> !irq)
    else $error("interrupt stayed high after status read");

endmodule

// file: pkg/rtcx_pkg.sv
// Package: register map, field layout, timing and shared types of the block
package rtcx_pkg;

  // ==========================================================================
  // Register indices and byte addresses (byte address is four times index)
  // ==========================================================================
  localparam logic [7:0] IDX_MODE = 8'h0b;
  localparam logic [7:0] IDX_STATUS = 8'h0c;
  localparam logic [7:0] IDX_MONTH = 8'h0d;
  localparam logic [7:0] IDX_CTL = 8'h10;
  localparam logic [7:0] ADDR_MODE = 8'h2c;
  localparam logic [7:0] ADDR_STATUS = 8'h30;
  localparam logic [7:0] ADDR_MONTH = 8'h34;
  localparam logic [7:0] ADDR_CTL = 8'h40;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int ST_SUMMARY = 7;
  localparam int ST_EVT_LO = 4;
  localparam int MODE_EN_LO = 4;
  localparam int CTL_ALARM_EN = 3;
  localparam int CTL_WAKE_ROUTE = 2;
  localparam int CTL_SOFT_RST = 1;
  localparam int CTL_RUN = 0;

  // ==========================================================================
  // Values after reset
  // ==========================================================================
  localparam logic [2:0] FLAGS_RST = 3'h0;
  localparam logic [5:0] MONTH_RST = 6'h00;
  localparam logic [2:0] IE_RST = 3'h0;
  localparam logic [3:0] CTL_RST = 4'h0;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int CLK_HZ = 40_000_000;
  localparam int STABLE_MS = 999;
  localparam int STABLE_CYC = STABLE_MS * (CLK_HZ / 1000);
  localparam logic [2:0] SRST_CYC = 3'h4;

  // ==========================================================================
  // Bus answers
  // ==========================================================================
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================================
  // Types
  // ==========================================================================
  // Event strobes from the time-keeping logic, one cycle each
  typedef struct packed {
    logic periodic;
    logic update_done;
    logic alarm_match;
  } rtcx_evt_t;

  typedef enum logic [1:0] {
    SRST_IDLE = 2'h0,
    SRST_HOLD = 2'h1,
    SRST_DONE = 2'h3
  } rtcx_srst_st_t;

  typedef struct packed {
    rtcx_srst_st_t st;
    logic [2:0] cnt;
  } rtcx_srst_t;

  // Flags order: [2] periodic, [1] alarm, [0] update ended
  typedef struct packed {
    logic aw_held;
    logic [7:0] aw_addr;
    logic w_held;
    logic [7:0] w_data;
    logic w_lane0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
    logic [2:0] flags;
    logic irq;
    logic [5:0] month;
    logic [2:0] ie;
    logic [3:0] ctl;
    logic wake;
    logic [25:0] stable_cnt;
  } rtcx_core_t;

endpackage

// file: src/rtcx_srst_seq.sv
// Domain reset sequencer started by the soft-reset control bit
module rtcx_srst_seq (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Request and result
  input wire logic req,
  output logic dom_rst,
  output logic done
);

  rtcx_pkg::rtcx_srst_t q;
  rtcx_pkg::rtcx_srst_t next_q;

  always_comb begin
    next_q = q;
    case (q.st)
      rtcx_pkg::SRST_IDLE: begin
        if (req) begin
          next_q.st = rtcx_pkg::SRST_HOLD;
          next_q.cnt = rtcx_pkg::SRST_CYC;
        end
      end
      rtcx_pkg::SRST_HOLD: begin
        next_q.cnt = q.cnt - 3'h1;
        if (q.cnt == 3'h1) begin
          next_q.st = rtcx_pkg::SRST_DONE;
        end
      end
      // One cycle only, so a fresh request is seen from idle again
      rtcx_pkg::SRST_DONE: begin
        next_q.st = rtcx_pkg::SRST_IDLE;
      end
      default: begin
        next_q.st = rtcx_pkg::SRST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '{st: rtcx_pkg::SRST_IDLE, cnt: 3'h0};
    end else begin
      q <= next_q;
    end
  end

  assign dom_rst = (q.st == rtcx_pkg::SRST_HOLD);
  assign done = (q.st == rtcx_pkg::SRST_DONE);

endmodule

// file: tb/rtc_irq_status_alarm_control_tb_top.sv
// Self-checking bench for the event status, month alarm and control block
module rtc_irq_status_alarm_control_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================================
  // Clock, reset, stimulus and bookkeeping
  // ==========================================================================
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  rtcx_pkg::rtcx_evt_t evt = '0;
  logic [7:0] cur_month = 8'h00;
  logic irq, wake_alarm, block_run, rtc_domain_rst, time_stable;
  int n_mismatch = 0;
  int n_checks = 0;
  int cyc = 0;
  int wake_cnt = 0;
  int drst_cnt = 0;
  integer seed = 32'h1ee3c5fe;

  rtcx_core #(.STABLE_CYCLES(20)) i_rtcx_core (
    .clk(clk), .nrst(nrst),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .evt(evt), .cur_month(cur_month), .irq(irq),
    .wake_alarm(wake_alarm), .block_run(block_run),
    .rtc_domain_rst(rtc_domain_rst), .time_stable(time_stable)
  );

  initial begin
    forever #12.5 clk = ~clk;
  end

  // Pulse monitors sample at the falling edge, away from register updates
  always @(negedge clk) begin
    if (wake_alarm === 1'b1) wake_cnt++;
    if (rtc_domain_rst === 1'b1) drst_cnt++;
  end

  // Whole run needs a few hundred cycles; a hang stops well past that
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      report_and_stop();
    end
  end

  // ==========================================================================
  // Checking and expectations
  // ==========================================================================
  task automatic report_and_stop();
    if (n_mismatch == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      n_mismatch++;
    end
  endtask

  // Flags in status order: [2] periodic, [1] alarm, [0] update ended
  function automatic logic [31:0] exp_st(input logic [2:0] f,
                                         input logic [2:0] ie);
    return {24'h0, |(f & ie), f, 4'h0};
  endfunction

  function automatic rtcx_pkg::rtcx_evt_t to_evt(input logic [2:0] f);
    rtcx_pkg::rtcx_evt_t e;
    e.periodic = f[2];
    e.alarm_match = f[1];
    e.update_done = f[0];
    return e;
  endfunction

  // ==========================================================================
  // Bus and event drivers
  // ==========================================================================
  // Ready is sampled on the falling edge, where it is settled until the
  // rising edge that completes the handshake
  task automatic wr(input logic [7:0] a, input logic [7:0] d,
                    input logic [3:0] s, output logic [1:0] r);
    logic ah;
    logic wh;
    logic bh;
    logic [31:0] rv;
    rv = $random(seed);
    bh = 1'b0;
    @(posedge clk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= {rv[31:8], d};
    wstrb <= s;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!bh) begin
      @(negedge clk);
      ah = awvalid && awready;
      wh = wvalid && wready;
      bh = bready && bvalid;
      r = bresp;
      @(posedge clk);
      if (ah) awvalid <= 1'b0;
      if (wh) wvalid <= 1'b0;
      if (bh) bready <= 1'b0;
    end
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    logic ah;
    logic dh;
    dh = 1'b0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!dh) begin
      @(negedge clk);
      ah = arvalid && arready;
      dh = rready && rvalid;
      d = rdata;
      r = rresp;
      @(posedge clk);
      if (ah) arvalid <= 1'b0;
      if (dh) rready <= 1'b0;
    end
  endtask

  task automatic w(input logic [7:0] a, input logic [7:0] d);
    logic [1:0] r;
    wr(a, d, 4'hf, r);
    chk(r, rtcx_pkg::RESP_OKAY);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(r, rtcx_pkg::RESP_OKAY);
    chk(d, exp);
  endtask

  task automatic pulse(input logic [2:0] f);
    @(posedge clk);
    evt <= to_evt(f);
    @(posedge clk);
    evt <= '0;
    @(negedge clk);
  endtask

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    logic [2:0] ie;
    logic [2:0] f;
    logic [5:0] m;
    int k;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    rchk(rtcx_pkg::ADDR_STATUS, 32'h0);
    rchk(rtcx_pkg::ADDR_MONTH, 32'h0);
    rchk(rtcx_pkg::ADDR_CTL, 32'h0);
    rchk(rtcx_pkg::ADDR_MODE, 32'h0);
    chk(block_run, 1'b0);
    // Alarm enabled but block stopped: nothing may be latched
    w(rtcx_pkg::ADDR_CTL, 8'h08);
    pulse(3'b111);
    rchk(rtcx_pkg::ADDR_STATUS, 32'h0);
    // Unmapped places answer with an error and read zero
    wr(8'h38, 8'h5a, 4'hf, r);
    chk(r, rtcx_pkg::RESP_SLVERR);
    rd(8'h3c, d, r);
    chk(r, rtcx_pkg::RESP_SLVERR);
    chk(d, 32'h0);
    // Divider chain sits outside this block; taken as set to 010b here
    w(rtcx_pkg::ADDR_CTL, 8'h09);
    chk(block_run, 1'b1);
    for (int i = 0; i < 10; i++) begin
      ie = (i == 0) ? 3'b000 : 3'($random(seed));
      f = (i < 2) ? 3'b111 : 3'($random(seed));
      @(posedge clk);
      cur_month <= 8'($random(seed));
      w(rtcx_pkg::ADDR_MODE, {1'b0, ie, 4'h0});
      pulse(f);
      chk(irq, |(f & ie));
      rchk(rtcx_pkg::ADDR_STATUS, exp_st(f, ie));
      chk(irq, 1'b0);
      rchk(rtcx_pkg::ADDR_STATUS, 32'h0);
    end
    // Write with no byte enabled leaves the register alone
    wr(rtcx_pkg::ADDR_MONTH, 8'h15, 4'h0, r);
    rchk(rtcx_pkg::ADDR_MONTH, 32'h0);
    w(rtcx_pkg::ADDR_MODE, 8'h00);
    m = 6'($random(seed));
    if (m == 6'h00) m = 6'h01;
    w(rtcx_pkg::ADDR_MONTH, {2'b00, m});
    rchk(rtcx_pkg::ADDR_MONTH, {26'h0, m});
    @(posedge clk);
    cur_month <= {2'b00, m ^ 6'h01};
    pulse(3'b010);
    rchk(rtcx_pkg::ADDR_STATUS, 32'h0);
    @(posedge clk);
    cur_month <= {2'b00, m};
    pulse(3'b010);
    rchk(rtcx_pkg::ADDR_STATUS, exp_st(3'b010, 3'b000));
    w(rtcx_pkg::ADDR_MONTH, 8'h00);
    @(posedge clk);
    cur_month <= {2'b00, m ^ 6'h2a};
    pulse(3'b010);
    rchk(rtcx_pkg::ADDR_STATUS, exp_st(3'b010, 3'b000));
    w(rtcx_pkg::ADDR_CTL, 8'h01);
    pulse(3'b010);
    rchk(rtcx_pkg::ADDR_STATUS, 32'h0);
    w(rtcx_pkg::ADDR_CTL, 8'h0d);
    k = wake_cnt;
    pulse(3'b010);
    @(posedge clk);
    chk(wake_cnt, k + 1);
    rchk(rtcx_pkg::ADDR_STATUS, exp_st(3'b010, 3'b000));
    w(rtcx_pkg::ADDR_CTL, 8'h09);
    pulse(3'b010);
    @(posedge clk);
    chk(wake_cnt, k + 1);
    rchk(rtcx_pkg::ADDR_STATUS, exp_st(3'b010, 3'b000));
    pulse(3'b001);
    repeat (2) @(negedge clk);
    chk(time_stable, 1'b1);
    repeat (25) @(negedge clk);
    chk(time_stable, 1'b0);
    rchk(rtcx_pkg::ADDR_STATUS, exp_st(3'b001, 3'b000));
    // Writing ones clears only the flags chosen
    pulse(3'b101);
    w(rtcx_pkg::ADDR_STATUS, 8'h40);
    rchk(rtcx_pkg::ADDR_STATUS, exp_st(3'b001, 3'b000));
    // Soft reset must wipe flags and settings but keep the control bits
    w(rtcx_pkg::ADDR_MODE, 8'h70);
    rchk(rtcx_pkg::ADDR_MODE, 32'h70);
    w(rtcx_pkg::ADDR_MONTH, 8'h07);
    w(rtcx_pkg::ADDR_CTL, 8'h0d);
    pulse(3'b100);
    chk(irq, 1'b1);
    k = drst_cnt;
    w(rtcx_pkg::ADDR_CTL, 8'h0f);
    repeat (12) @(posedge clk);
    chk(drst_cnt - k, 4);
    chk(irq, 1'b0);
    rchk(rtcx_pkg::ADDR_CTL, 32'h0d);
    rchk(rtcx_pkg::ADDR_MONTH, 32'h0);
    rchk(rtcx_pkg::ADDR_MODE, 32'h0);
    rchk(rtcx_pkg::ADDR_STATUS, 32'h0);
    chk(block_run, 1'b1);
    report_and_stop();
  end

endmodule
